//--- mrx_exec.sv
// move and return instruction executor of the 8-bit core
`timescale 1ns/1ps
module mrx_exec
   import mrx_pkg::*;
(
   input  wire logic              CLK,
   input  wire logic              RESET,
   input  wire logic              INSTR_VALID,
   input  wire logic [2:0]        INSTR_OP,
   input  wire logic [ADDR_W-1:0] INSTR_ADDR,
   input  wire logic              INSTR_DIR,
   input  wire logic [DATA_W-1:0] INSTR_LIT,
   input  wire logic              CALL_PUSH,
   input  wire logic [PC_W-1:0]   CALL_TARGET,
   input  wire logic [DATA_W-1:0] FILE_RDATA,
   output logic                   INSTR_READY,
   output logic      [ADDR_W-1:0] FILE_ADDR,
   output logic      [DATA_W-1:0] FILE_WDATA,
   output logic                   FILE_WE,
   output logic      [DATA_W-1:0] WORK,
   output logic                   ZERO,
   output logic                   GLB_EN_SET,
   output logic      [PC_W-1:0]   PC,
   output logic      [STK_AW-1:0] STACK_PTR
);
   mrx_state_e        state_r;
   mrx_state_e        state_nxt;
   logic [PC_W-1:0]   top;
   logic              take;
   logic              is_ret;
   logic              pop;
   mrx_op_e           op;

   // ==========================================
   // decode helpers
   function automatic logic op_is_return(input mrx_op_e o);
      return (o == MRX_RETI) || (o == MRX_RETL) || (o == MRX_RET);
   endfunction : op_is_return

   assign op          = mrx_op_e'(INSTR_OP);
   assign INSTR_READY = (state_r == MRX_IDLE);   // stalls fetch during the flush cycle
   assign take        = INSTR_VALID && INSTR_READY;
   assign is_ret      = op_is_return(op);
   assign pop         = take && is_ret;

   mrx_stack u_stack (
      .CLK       (CLK),
      .RESET     (RESET),
      .push      (CALL_PUSH && !pop),
      .pop       (pop),
      .push_data (CALL_TARGET),
      .top_r     (top),
      .sp_r      (STACK_PTR)
   );

   // ==========================================
   // sequencer: returns spend a second cycle flushing the fetched word
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         MRX_IDLE:  if (pop) state_nxt = MRX_FLUSH;
         MRX_FLUSH: state_nxt = MRX_IDLE;
         default:   state_nxt = MRX_IDLE;
      endcase
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) state_r <= MRX_IDLE;
      else       state_r <= state_nxt;
   end

   // ==========================================
   // file register port; address is combinational so the read lands in the same cycle
   assign FILE_ADDR = INSTR_ADDR;

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         FILE_WE    <= 1'b0;
         FILE_WDATA <= W_RESET;
      end else begin
         FILE_WE <= 1'b0;
         if (take && op == MRX_WTOF) begin
            FILE_WE    <= 1'b1;
            FILE_WDATA <= WORK;
         end else if (take && op == MRX_FMOVE && INSTR_DIR == DIR_TO_FILE) begin
            FILE_WE    <= 1'b1;
            FILE_WDATA <= FILE_RDATA;
         end
      end
   end

   // ==========================================
   // working register
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         WORK <= W_RESET;
      end else if (take) begin
         unique case (op)
            MRX_FMOVE: if (INSTR_DIR == DIR_TO_WORK) WORK <= FILE_RDATA;
            MRX_LDLIT: WORK <= INSTR_LIT;
            MRX_RETL:  WORK <= INSTR_LIT;
            default:   WORK <= WORK;
         endcase
      end
   end

   // zero flag: only the file move touches it; a write-back keeps the zero test usable
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) ZERO <= 1'b0;
      else if (take && op == MRX_FMOVE) ZERO <= (FILE_RDATA == 8'h00);
   end

   // global enable set pulse toward irq control bit GLB_EN_BIT; a pulse, not a level,
   // so the irq control block keeps sole ownership of the enable bit
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) GLB_EN_SET <= 1'b0;
      else       GLB_EN_SET <= take && op == MRX_RETI;
   end

   // ==========================================
   // program counter: one step per instruction, stack top on return
   // the stack top is registered, so a push just before a return is already visible
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET)    PC <= PC_RESET;
      else if (pop) PC <= top;
      else if (take) PC <= PC + 13'h0001;
   end

   // ==========================================
   // checks
   sequence ret_take_s;
      INSTR_VALID && INSTR_READY && op_is_return(op);
   endsequence
   sequence flush_s;
      !INSTR_READY ##1 INSTR_READY;
   endsequence
   // a single-cycle instruction leaves the executor ready for the next word
   sequence move_take_s;
      INSTR_VALID && INSTR_READY && !op_is_return(op);
   endsequence

   // return timing, program counter and global enable
   ret_two_cyc_a: assert property (@(posedge CLK) disable iff (RESET)
      ret_take_s |=> flush_s) else $error("return did not take two cycles");
   ret_pc_a: assert property (@(posedge CLK) disable iff (RESET)
      ret_take_s |=> PC == $past(top)) else $error("pc not loaded from stack top");
   reti_enable_a: assert property (@(posedge CLK) disable iff (RESET)
      (take && op == MRX_RETI) |=> GLB_EN_SET) else $error("global enable not set");

   // file move: destination and zero flag
   fmove_zero_a: assert property (@(posedge CLK) disable iff (RESET)
      (take && op == MRX_FMOVE) |=> ZERO == ($past(FILE_RDATA) == 8'h00))
      else $error("zero flag wrong after file move");
   fmove_dest_a: assert property (@(posedge CLK) disable iff (RESET)
      (take && op == MRX_FMOVE && INSTR_DIR) |=> FILE_WE && $stable(WORK))
      else $error("file move to file went wrong");

   // work-to-file move and literal load
   wtof_data_a: assert property (@(posedge CLK) disable iff (RESET)
      (take && op == MRX_WTOF) |=> FILE_WE && FILE_WDATA == WORK && $stable(ZERO))
      else $error("work to file move wrong");
   lit_load_a: assert property (@(posedge CLK) disable iff (RESET)
      (take && op == MRX_LDLIT) |=> WORK == $past(INSTR_LIT) && $stable(ZERO))
      else $error("literal load wrong");

   // literal return
   retl_lit_a: assert property (@(posedge CLK) disable iff (RESET)
      (take && op == MRX_RETL) |=> WORK == $past(INSTR_LIT) && PC == $past(top))
      else $error("literal return wrong");
   retl_cyc_a: assert property (@(posedge CLK) disable iff (RESET)
      (take && op == MRX_RETL) |=> !INSTR_READY) else $error("literal return one cycle");

   // no-op leaves every piece of state but the program counter alone
   nop_still_a: assert property (@(posedge CLK) disable iff (RESET)
      (take && op == MRX_NOP) |=> $stable(WORK) && $stable(ZERO) && !FILE_WE && INSTR_READY)
      else $error("no-op changed state");

   // zero flag belongs to the file move alone
   zero_hold_a: assert property (@(posedge CLK) disable iff (RESET)
      (take && op != MRX_FMOVE) |=> $stable(ZERO))
      else $error("zero flag moved outside file move");
   // the work register is only read by the work-to-file move
   wtof_work_a: assert property (@(posedge CLK) disable iff (RESET)
      (take && op == MRX_WTOF) |=> $stable(WORK))
      else $error("work changed by work to file move");
   // interrupt return touches neither flags nor work
   reti_flags_a: assert property (@(posedge CLK) disable iff (RESET)
      (take && op == MRX_RETI) |=> $stable(ZERO) && $stable(WORK))
      else $error("interrupt return changed state");
   // each return takes exactly one entry off the stack
   ret_stack_a: assert property (@(posedge CLK) disable iff (RESET)
      (take && op == MRX_RET) |=> STACK_PTR == $past(STACK_PTR) - 3'h1)
      else $error("return did not pop the stack");
   retl_stack_a: assert property (@(posedge CLK) disable iff (RESET)
      (take && op == MRX_RETL) |=> STACK_PTR == $past(STACK_PTR) - 3'h1)
      else $error("literal return did not pop the stack");
   // moves and no-op never stall the fetch and step the pc by one
   move_one_cyc_a: assert property (@(posedge CLK) disable iff (RESET)
      move_take_s |=> INSTR_READY)
      else $error("single cycle instruction stalled");
   pc_step_a: assert property (@(posedge CLK) disable iff (RESET)
      move_take_s |=> PC == $past(PC) + 13'h0001)
      else $error("pc did not step by one");
   // the enable request is a single pulse; the flush cycle keeps it from repeating
   enable_pulse_a: assert property (@(posedge CLK) disable iff (RESET)
      GLB_EN_SET |=> !GLB_EN_SET)
      else $error("global enable pulse too long");
   // nothing is executed in the flush cycle of a return
   flush_hold_a: assert property (@(posedge CLK) disable iff (RESET)
      !INSTR_READY |=> $stable(PC) && $stable(WORK))
      else $error("state changed during flush");
endmodule : mrx_exec

//--- mrx_pkg.sv
// package of constants and types for the move and return instruction executor
package mrx_pkg;
   // ==========================================
   // widths
   localparam int DATA_W  = 8;
   localparam int ADDR_W  = 7;
   localparam int PC_W    = 13;
   localparam int STK_D   = 8;
   localparam int STK_AW  = 3;
   // ==========================================
   // field positions and reset values
   localparam int GLB_EN_BIT = 7;                 // global enable inside irq control
   localparam logic [ADDR_W-1:0] IRQ_CTRL_ADDR  = 7'h0b;
   localparam logic [DATA_W-1:0] W_RESET        = 8'h00;
   localparam logic [PC_W-1:0]   PC_RESET       = 13'h0000;
   localparam logic [STK_AW-1:0] SP_RESET       = 3'h0;
   localparam logic              DIR_TO_WORK    = 1'b0;
   localparam logic              DIR_TO_FILE    = 1'b1;
   // ==========================================
   // cycle counts
   localparam logic [1:0] CYC_SINGLE = 2'h1;
   localparam logic [1:0] CYC_RETURN = 2'h2;
   // ==========================================
   // operation codes presented by the decode stage
   typedef enum logic [2:0] {
      MRX_NOP   = 3'h0,
      MRX_FMOVE = 3'h1,
      MRX_WTOF  = 3'h2,
      MRX_LDLIT = 3'h3,
      MRX_RETI  = 3'h4,
      MRX_RETL  = 3'h5,
      MRX_RET   = 3'h6
   } mrx_op_e;
   // executor states, gray coded along idle -> flush -> idle
   typedef enum logic [1:0] {
      MRX_IDLE  = 2'b00,
      MRX_FLUSH = 2'b01
   } mrx_state_e;
endpackage : mrx_pkg

//--- mrx_stack.sv
// hardware return stack with registered top-of-stack output
`timescale 1ns/1ps
module mrx_stack
   import mrx_pkg::*;
(
   input  wire logic              CLK,
   input  wire logic              RESET,
   input  wire logic              push,
   input  wire logic              pop,
   input  wire logic [PC_W-1:0]   push_data,
   output logic      [PC_W-1:0]   top_r,
   output logic      [STK_AW-1:0] sp_r
);
   logic [PC_W-1:0] mem [STK_D];
   // ==========================================
   // storage; the stack wraps on overflow as a circular buffer
   always_ff @(posedge CLK) begin
      if (push) begin
         mem[sp_r] <= push_data;
      end
   end
   // pointer
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         sp_r <= SP_RESET;
      end else if (push) begin
         sp_r <= sp_r + 3'h1;
      end else if (pop) begin
         sp_r <= sp_r - 3'h1;
      end
   end
   // registered top value, read one below the pointer after each change
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         top_r <= PC_RESET;
      end else if (push) begin
         top_r <= push_data;
      end else if (pop) begin
         top_r <= mem[sp_r - 3'h2];
      end else begin
         top_r <= mem[sp_r - 3'h1];
      end
   end
endmodule : mrx_stack

//--- mrx_file_model.sv
// file register model answering the executor's combinational reads
`timescale 1ns/1ps
module mrx_file_model
   import mrx_pkg::*;
(
   input  wire logic              CLK,
   input  wire logic [ADDR_W-1:0] FILE_ADDR,
   input  wire logic [DATA_W-1:0] FILE_WDATA,
   input  wire logic              FILE_WE,
   output logic      [DATA_W-1:0] FILE_RDATA
);
   logic [DATA_W-1:0] mem [128];
   logic [ADDR_W-1:0] addr_r;
   // preset pattern leaves exactly one address reading zero
   initial begin
      for (int i = 0; i < 128; i++) mem[i] = 8'(i) ^ 8'h5a;
   end
   // the executor's write lands a cycle after its take, so a pending write to the
   // address being read is forwarded; otherwise back-to-back moves read stale data
   assign FILE_RDATA = (FILE_WE && addr_r == FILE_ADDR) ? FILE_WDATA : mem[FILE_ADDR];
   // the write pulse lags the take by a cycle, so use the address seen then
   always @(posedge CLK) begin
      addr_r <= FILE_ADDR;
      if (FILE_WE) mem[addr_r] <= FILE_WDATA;
   end
endmodule : mrx_file_model

//--- testbench.sv
// self-checking bench for the move and return executor
`timescale 1ns/1ps
module testbench import mrx_pkg::*;;
   typedef struct packed {
      logic [DATA_W-1:0] w;
      logic              z;
      logic [PC_W-1:0]   pc;
      logic              we;
      logic [DATA_W-1:0] wd;
      logic              ien;
      logic [STK_AW-1:0] sp;
   } mrx_note_s;
   logic clk, reset, valid, dir, cpush, ready, fwe, zero, ien;
   logic [2:0] op;
   logic [ADDR_W-1:0] addr, faddr;
   logic [DATA_W-1:0] lit, rdata, fwd, work;
   logic [PC_W-1:0] ctgt, pc;
   logic [STK_AW-1:0] sp;
   logic [DATA_W-1:0] m_mem [128];
   logic [PC_W-1:0] m_stk [8];
   mrx_note_s m, notes[$];
   int errors, tests_run, depth, cycles;
   mrx_exec dut_u (.CLK(clk), .RESET(reset), .INSTR_VALID(valid), .INSTR_OP(op),
      .INSTR_ADDR(addr), .INSTR_DIR(dir), .INSTR_LIT(lit), .CALL_PUSH(cpush),
      .CALL_TARGET(ctgt), .FILE_RDATA(rdata), .INSTR_READY(ready), .FILE_ADDR(faddr),
      .FILE_WDATA(fwd), .FILE_WE(fwe), .WORK(work), .ZERO(zero), .GLB_EN_SET(ien),
      .PC(pc), .STACK_PTR(sp));
   mrx_file_model file_u (.CLK(clk), .FILE_ADDR(faddr), .FILE_WDATA(fwd),
      .FILE_WE(fwe), .FILE_RDATA(rdata));
   always #10 clk = ~clk;
   // ==========================================
   // reporting
   task summarize;
      if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // ==========================================
   // drivers: inputs move 1 ns after the rising edge
   task push(input logic [PC_W-1:0] t);
      cpush = 1'b1;
      ctgt = t;
      m_stk[m.sp] = t;
      m.sp++;
      depth++;
      @(posedge clk);
      #1 cpush = 1'b0;
   endtask : push
   task issue(input logic [2:0] o, input logic [ADDR_W-1:0] a, input logic d,
              input logic [DATA_W-1:0] k);
      logic [DATA_W-1:0] v;
      v = m_mem[a];
      m.we = 1'b0;
      m.ien = 1'b0;
      m.pc++;
      case (o)
         MRX_FMOVE: begin
            if (d == DIR_TO_WORK) m.w = v;
            m.z = (v == 8'h00);
            m.we = d;
            if (d == DIR_TO_FILE) m.wd = v;
         end
         MRX_WTOF: begin
            m_mem[a] = m.w;
            m.we = 1'b1;
            m.wd = m.w;
         end
         MRX_LDLIT: m.w = k;
         MRX_RETI, MRX_RETL, MRX_RET: begin
            m.sp--;
            m.pc = m_stk[m.sp];
            depth--;
            if (o == MRX_RETL) m.w = k;
            m.ien = (o == MRX_RETI);
         end
         default: ;
      endcase
      notes.push_back(m);
      {valid, op, addr, dir, lit} = {1'b1, o, a, d, k};
      @(posedge clk);
      #1 valid = 1'b0;
      if (o >= 3'h4) begin
         chk(ready, 0);
         @(posedge clk);
         #1;
      end
   endtask : issue
   // ==========================================
   // monitor: one note per taken instruction, checked at the next falling edge
   always @(posedge clk) begin : mon
      mrx_note_s n;
      if ((valid && ready) === 1'b1) begin
         @(negedge clk);
         n = notes.pop_front();
         chk(work, n.w);
         chk(zero, n.z);
         chk(pc, n.pc);
         chk({fwe, fwd}, {n.we, n.wd});
         chk(ien, n.ien);
         chk(sp, n.sp);
      end
   end
   // bound on run length; a hang counts as a mismatch
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         summarize();
      end
   end
   initial begin
      {clk, reset, valid, op, addr, dir, lit, cpush, ctgt} = '0;
      reset = 1'b1;
      for (int i = 0; i < 128; i++) m_mem[i] = 8'(i) ^ 8'h5a;
      m = '0;
      void'($urandom(60460));
      repeat (5) @(posedge clk);
      #1 reset = 1'b0;
      chk({ready, work, pc, sp}, 25'h1000000);
      issue(MRX_LDLIT, 0, 0, 8'hff);
      issue(MRX_WTOF, 7'h7f, 0, 0);
      issue(MRX_FMOVE, 7'h7f, 0, 0);
      issue(MRX_FMOVE, 7'h5a, 1, 0);
      issue(MRX_LDLIT, 0, 0, 8'h00);
      issue(MRX_NOP, 0, 0, 0);
      push(13'h1abc);
      push(13'h0123);
      push(13'h1fff);
      issue(MRX_RETL, 0, 0, 8'h3c);
      issue(MRX_RETI, 0, 0, 0);
      issue(MRX_RET, 0, 0, 0);
      // random mix, pushing first whenever a pop would underflow
      repeat (80) begin
         op = 3'($urandom_range(6, 0));
         if ((op >= 3'h4 && depth == 0) || ($urandom_range(3, 0) == 0 && depth < 7))
            push(13'($urandom));
         issue(op, 7'($urandom), 1'($urandom), 8'($urandom));
      end
      @(posedge clk);
      @(posedge clk);
      summarize();
   end
endmodule : testbench
